// ==== uvfrs_pkg.sv ====
// Function
// - hold-off code: off during fault, on after
// - retry field sets attempts, all-ones unlimited
// - attempts exhausted with fault: output latched off
// - latch cleared by reset or power cycle
// - delay two spaces successive restart attempts
// - delay one precedes disabling after fault with code 01 only
// - code 01: run delay one, then retry
// - code 10: shut down at once, retry
//
// constants and types for the undervoltage fault retry sequencer
// assumes a 100 MHz device clock and a comparator fault level on that clock
package uvfrs_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int NS_PER_MS     = 1_000_000;
  localparam int MS_CYCLES_DFLT = NS_PER_MS / CLK_PERIOD_NS;  // cycles per millisecond

  // delay one, in ms: 10 20 40 80 160 320 640 1280
  localparam logic [11:0] DELAY1_MS [8] = '{12'h00a, 12'h014, 12'h028, 12'h050,
                                           12'h0a0, 12'h140, 12'h280, 12'h500};
  // delay two, in ms: 252 558 924 1260 1596 1932 2268 2604
  localparam logic [11:0] DELAY2_MS [8] = '{12'h0fc, 12'h22e, 12'h39c, 12'h4ec,
                                           12'h63c, 12'h78c, 12'h8dc, 12'ha2c};

  // ----------------------------------------------------------------
  // control register
  // ----------------------------------------------------------------
  localparam logic [7:0] CTRL_RESET     = 8'h00;
  localparam logic [2:0] RETRY_INFINITE = 3'h7;
  localparam logic [2:0] CNT_ONE        = 3'h1;
  localparam logic [11:0] MS_MAX        = 12'hfff;

  typedef enum logic [1:0] {
    RESP_IGNORE  = 2'h0,  // do nothing
    RESP_DELAYED = 2'h1,  // keep running delay one, then shut down and retry
    RESP_NOW     = 2'h2,  // shut down at once and retry
    RESP_HOLD    = 2'h3   // off until the fault clears
  } uvfrs_resp_e;

  // bits [7:6] response, [5:3] retries, [2:0] delay select
  typedef struct packed {
    uvfrs_resp_e response;
    logic [2:0]  retries;
    logic [2:0]  delay_sel;
  } uvfrs_ctrl_s;

  typedef enum logic [2:0] {
    ST_RUN,
    ST_DELAY1,
    ST_HOLD_OFF,
    ST_RETRY_WAIT,
    ST_LATCHED
  } uvfrs_state_e;

endpackage

// ==== uvfrs_top.sv ====
// undervoltage fault response sequencer: control register, state machine,
// millisecond timer and attempt counter driving the output enable
// assumes fault and power_on come from logic on the same clock
`timescale 1ns/1ps
module uvfrs_top #(
  parameter int MS_CYCLES = uvfrs_pkg::MS_CYCLES_DFLT  // clock cycles per ms
) (
  input  wire logic                   clk,         // 100 MHz device clock
  input  wire logic                   rstn,        // async reset, active low
  input  wire logic                   ctrl_we,     // control register write strobe
  input  wire uvfrs_pkg::uvfrs_ctrl_s ctrl_wdata,  // control register write data
  input  wire logic                   fault,       // undervoltage fault level
  input  wire logic                   power_on,    // operation on; low means off
  output logic                        out_en,      // power stage output enable
  output uvfrs_pkg::uvfrs_ctrl_s      ctrl_q,      // control register readback
  output uvfrs_pkg::uvfrs_state_e     state_q,     // sequencer state
  output logic [2:0]                  retry_cnt_q, // restart attempts made
  output logic                        latched_q    // output latched off
);
  import uvfrs_pkg::*;

  uvfrs_state_e state_reg;
  uvfrs_state_e state_next;
  logic [31:0]  pre_reg;
  logic [11:0]  ms_reg;
  logic [2:0]   cnt_reg;
  logic         out_en_reg;
  logic [2:0]   lim;
  logic [11:0]  d1_ms;
  logic [11:0]  d2_ms;
  logic         expire1;
  logic         expire2;
  logic         limit_hit;
  logic         restart;
  logic         latched_reg;

  // ----------------------------------------------------------------
  // control register
  // ----------------------------------------------------------------
  // software write port
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      ctrl_q <= uvfrs_ctrl_s'(CTRL_RESET);
    else if (ctrl_we)
      ctrl_q <= ctrl_wdata;
  end

  // decoded delays and limit
  assign lim       = ctrl_q.retries;
  assign d1_ms     = DELAY1_MS[ctrl_q.delay_sel];
  assign d2_ms     = DELAY2_MS[ctrl_q.delay_sel];
  assign expire1   = ms_reg >= d1_ms;
  assign expire2   = ms_reg >= d2_ms;
  assign limit_hit = (lim != RETRY_INFINITE) && (cnt_reg >= lim);
  assign restart   = (state_reg == ST_RETRY_WAIT) && expire2 && power_on;

  // ----------------------------------------------------------------
  // state machine
  // ----------------------------------------------------------------
  // next state from fault, response and timers
  always_comb
  begin
    state_next = state_reg;
    unique case (state_reg)
      ST_RUN:
      begin
        if (fault)
        begin
          unique case (ctrl_q.response)
            RESP_DELAYED: state_next = ST_DELAY1;
            RESP_NOW:     state_next = limit_hit ? ST_LATCHED : ST_RETRY_WAIT;
            RESP_HOLD:    state_next = ST_HOLD_OFF;
            RESP_IGNORE:  state_next = ST_RUN;
          endcase
        end
      end
      ST_DELAY1:
      begin
        if (!fault)
          state_next = ST_RUN;
        else if (expire1)
          state_next = limit_hit ? ST_LATCHED : ST_RETRY_WAIT;
      end
      ST_HOLD_OFF:
      begin
        if (!fault)
          state_next = ST_RUN;
      end
      ST_RETRY_WAIT:
      begin
        if (expire2)
          state_next = ST_RUN;
      end
      ST_LATCHED:
      begin
        state_next = ST_LATCHED;
      end
    endcase
    if (!power_on)
      state_next = ST_RUN;
  end

  // state register
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      state_reg <= ST_RUN;
    else
      state_reg <= state_next;
  end

  // ----------------------------------------------------------------
  // millisecond timer, restarted on every state change
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      pre_reg <= 32'h0000_0000;
      ms_reg  <= 12'h000;
    end
    else if (state_next != state_reg)
    begin
      pre_reg <= 32'h0000_0000;
      ms_reg  <= 12'h000;
    end
    else if (pre_reg == 32'(MS_CYCLES - 1))
    begin
      pre_reg <= 32'h0000_0000;
      if (ms_reg != MS_MAX)
        ms_reg <= ms_reg + 12'h001;
    end
    else
      pre_reg <= pre_reg + 32'h0000_0001;
  end

  // ----------------------------------------------------------------
  // attempt counter
  // ----------------------------------------------------------------
  // clear on fault clear, count restarts
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      cnt_reg <= 3'h0;
    else if (!power_on || (state_reg == ST_RUN && !fault))
      cnt_reg <= 3'h0;
    else if (restart && cnt_reg != RETRY_INFINITE)
      cnt_reg <= cnt_reg + CNT_ONE;
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // enable only while running or in delay one
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      out_en_reg <= 1'b0;
    else
      out_en_reg <= power_on && (state_next == ST_RUN || state_next == ST_DELAY1);
  end

  // latched-off indicator
  // registered from the next state so it tracks the state register exactly
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      latched_reg <= 1'b0;
    else
      latched_reg <= (state_next == ST_LATCHED);
  end

  assign out_en      = out_en_reg;
  assign state_q     = state_reg;
  assign retry_cnt_q = cnt_reg;
  assign latched_q   = latched_reg;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);

  sequence s_restart_due;
    state_reg == ST_RETRY_WAIT && power_on && expire2;
  endsequence

  sequence s_back_on;
    state_reg == ST_RUN ##0 out_en;
  endsequence

  a_hold_while_fault : assert property (
    state_reg == ST_HOLD_OFF && fault && power_on |=> state_reg == ST_HOLD_OFF && !out_en)
    else $error("output left hold-off during fault");
  a_hold_release : assert property (
    state_reg == ST_HOLD_OFF && !fault && power_on |=> s_back_on)
    else $error("output not re-enabled after fault cleared");
  a_retry_entry : assert property (
    state_reg == ST_RETRY_WAIT && $past(state_reg) != ST_RETRY_WAIT
    |-> $past(lim) == RETRY_INFINITE || retry_cnt_q < $past(lim))
    else $error("retry started beyond programmed limit");
  a_latch_on_limit : assert property (
    latched_q && !$past(latched_q) |-> $past(lim) != RETRY_INFINITE && !out_en)
    else $error("latched off with unlimited retries or output on");
  a_latch_sticky : assert property (
    latched_q && power_on |=> latched_q && !out_en)
    else $error("latch released without reset or power cycle");
  a_restart_spacing : assert property (
    s_restart_due |=> s_back_on)
    else $error("restart not made after delay two");
  a_no_early_restart : assert property (
    state_reg == ST_RETRY_WAIT && !expire2 && power_on |=> state_reg == ST_RETRY_WAIT && !out_en)
    else $error("restart before delay two elapsed");
  a_delay1_running : assert property (
    state_reg == ST_DELAY1 && fault && !expire1 && power_on |=> state_reg == ST_DELAY1 && out_en)
    else $error("output dropped before delay one elapsed");
  a_delay1_shut : assert property (
    state_reg == ST_DELAY1 && fault && expire1 |=> !out_en)
    else $error("output still on after delay one with fault");
  a_immediate_shut : assert property (
    state_reg == ST_RUN && fault && ctrl_q.response == RESP_NOW |=> !out_en)
    else $error("immediate response did not shut down");
  a_count_clear : assert property (
    state_reg == ST_RUN && !fault |=> retry_cnt_q == 3'h0)
    else $error("attempt count not cleared on fault clear");
  a_count_step : assert property (
    s_restart_due ##0 retry_cnt_q != RETRY_INFINITE |=> retry_cnt_q == $past(retry_cnt_q) + CNT_ONE)
    else $error("attempt count not advanced on restart");

endmodule

// ==== uvfrs_stage_model.sv ====
// power stage model: turns a forced sag into a clocked fault level
// assumes the bench owns force_uv and samples rises
`timescale 1ns/1ps
module uvfrs_stage_model (
  input  wire logic       clk,       // device clock
  input  wire logic       rstn,      // async reset, active low
  input  wire logic       out_en,    // enable from the sequencer
  input  wire logic       force_uv,  // bench-commanded output sag
  output logic            fault,     // comparator fault level
  output logic [7:0]      rises      // enable rising edges seen
);
  logic en_d;
  // comparator output registered on the device clock
  always_ff @(posedge clk or negedge rstn)
    if (!rstn)
    begin
      fault <= 1'b0;
      en_d  <= 1'b0;
      rises <= 8'h00;
    end
    else
    begin
      fault <= force_uv;
      en_d  <= out_en;
      rises <= rises + 8'((out_en && !en_d) ? 1 : 0);  // restart attempts seen
    end
endmodule

// ==== tb_top.sv ====
// scenario testbench for the undervoltage fault sequencer
// assumes MS_CYCLES shrunk to 4 so delays stay short
`timescale 1ns/1ps
module tb_top;
  import uvfrs_pkg::*;
  // ----------------------------------------------------------------
  // signals and instances
  // ----------------------------------------------------------------
  localparam int MS = 4;
  localparam int D1 = 10 * MS;
  localparam int D2 = 252 * MS;
  localparam int D1S = 20 * MS;   // delay one at select one
  localparam int D2S = 558 * MS;  // delay two at select one
  logic         clk = 0, rstn = 0, ctrl_we = 0, power_on = 1, force_uv = 0;
  uvfrs_ctrl_s  ctrl_wdata = '0;
  uvfrs_ctrl_s  ctrl_q;
  uvfrs_state_e state_q;
  logic         fault, out_en, latched_q;
  logic [2:0]   retry_cnt_q;
  logic [7:0]   rises, r0;
  int           fails = 0, tests_run = 0, cyc = 0, n;
  uvfrs_top #(.MS_CYCLES(MS)) i_uvfrs_top (.clk(clk), .rstn(rstn), .ctrl_we(ctrl_we),
    .ctrl_wdata(ctrl_wdata), .fault(fault), .power_on(power_on), .out_en(out_en),
    .ctrl_q(ctrl_q), .state_q(state_q), .retry_cnt_q(retry_cnt_q), .latched_q(latched_q));
  uvfrs_stage_model i_uvfrs_stage_model (.clk(clk), .rstn(rstn), .out_en(out_en),
    .force_uv(force_uv), .fault(fault), .rises(rises));
  always #5 clk = ~clk;
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic print_verdict();
    if (fails == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // cycle ceiling cuts a hang short
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      fails++;
      print_verdict();
    end
  end
  task automatic cmp(input string nm, input logic [7:0] e, input logic [7:0] g);
    tests_run++;
    if (g !== e)
    begin
      fails++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic rng(input string nm, input int v, input int lo, input int hi);
    tests_run++;
    if (v < lo || v > hi)
    begin
      fails++;
      $display("ERROR %s expected %0d..%0d seen %0d", nm, lo, hi, v);
    end
  endtask
  task automatic step(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  task automatic wait_en(input logic v, input int mx);
    n = 0;
    #1;  // look only at settled outputs
    while (out_en !== v && n < mx)
    begin
      step(1);
      n++;
    end
  endtask
  task automatic wr(input logic [7:0] v);
    @(posedge clk) ctrl_we <= 1'b1;
    ctrl_wdata <= uvfrs_ctrl_s'(v);
    @(posedge clk) ctrl_we <= 1'b0;
    #1 cmp("ctrl_q", v, ctrl_q);
  endtask
  task automatic pcycle();
    @(posedge clk) power_on <= 1'b0;
    step(3);
    cmp("out_en_off", 8'h00, out_en);
    @(posedge clk) power_on <= 1'b1;
    step(3);
    cmp("latched", 8'h00, latched_q);
    cmp("retry_cnt", 8'h00, retry_cnt_q);
    cmp("out_en", 8'h01, out_en);
  endtask
  // mid-run device reset must clear a latched output
  task automatic rst_pulse();
    @(posedge clk) rstn <= 1'b0;
    step(3);
    @(posedge clk) rstn <= 1'b1;
    step(2);
    cmp("latched_rst", 8'h00, latched_q);
    cmp("ctrl_rst2", CTRL_RESET, ctrl_q);
    cmp("out_en_rst2", 8'h01, out_en);
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_ignore();
    @(posedge clk) force_uv <= 1'b1;
    step(50);
    cmp("out_en_ign", 8'h01, out_en);
    @(posedge clk) force_uv <= 1'b0;
    step(3);
  endtask
  task automatic t_hold();
    wr(8'hc0);
    @(posedge clk) force_uv <= 1'b1;
    wait_en(1'b0, 6);
    step(30);
    cmp("out_en_hold", 8'h00, out_en);
    cmp("state_hold", ST_HOLD_OFF, state_q);
    @(posedge clk) force_uv <= 1'b0;
    wait_en(1'b1, 6);
    cmp("out_en_back", 8'h01, out_en);
  endtask
  task automatic t_now();
    wr(8'h88);
    @(posedge clk) force_uv <= 1'b1;
    wait_en(1'b0, 6);
    rng("shut_now", n, 0, 4);
    cmp("state_rw", ST_RETRY_WAIT, state_q);
    wait_en(1'b1, D2 + 20);
    rng("delay2", n, D2, D2 + 5);
    cmp("retry_cnt", 8'h01, retry_cnt_q);
    wait_en(1'b0, 6);
    cmp("latched", 8'h01, latched_q);
    @(posedge clk) force_uv <= 1'b0;
    step(20);
    cmp("out_en_latch", 8'h00, out_en);
    rst_pulse();
    pcycle();
  endtask
  task automatic t_delayed();
    wr(8'h40);
    @(posedge clk) force_uv <= 1'b1;
    step(D1 / 2);
    @(posedge clk) force_uv <= 1'b0;
    step(D1 + 10);
    cmp("out_en_short", 8'h01, out_en);
    @(posedge clk) force_uv <= 1'b1;
    wait_en(1'b0, D1 + 20);
    rng("delay1", n, D1, D1 + 6);
    cmp("latched_d1", 8'h01, latched_q);
    @(posedge clk) force_uv <= 1'b0;
    pcycle();
  endtask
  // delayed response, one retry, delay select one
  task automatic t_sel();
    wr(8'h49);
    @(posedge clk) force_uv <= 1'b1;
    wait_en(1'b0, D1S + 20);
    rng("delay1_sel", n, D1S, D1S + 6);
    cmp("state_sel", ST_RETRY_WAIT, state_q);
    wait_en(1'b1, D2S + 20);
    rng("delay2_sel", n, D2S, D2S + 5);
    wait_en(1'b0, D1S + 20);
    rng("delay1_again", n, D1S, D1S + 6);
    cmp("latched_sel", 8'h01, latched_q);
    @(posedge clk) force_uv <= 1'b0;
    pcycle();
  endtask
  task automatic t_unlimited();
    wr(8'hb8);
    r0 = rises;
    @(posedge clk) force_uv <= 1'b1;
    repeat (8)
    begin
      wait_en(1'b0, 6);
      wait_en(1'b1, D2 + 10);
    end
    // the model counts a rise one edge after it appears
    step(1);
    cmp("attempts", 8'h08, rises - r0);
    cmp("latched_inf", 8'h00, latched_q);
    cmp("retry_sat", 8'h07, retry_cnt_q);
    @(posedge clk) force_uv <= 1'b0;
    // count clears once the output is back on with no fault
    wait_en(1'b1, D2 + 10);
    step(6);
    cmp("retry_clr", 8'h00, retry_cnt_q);
  endtask
  // main sequence
  initial
  begin
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    step(2);
    cmp("ctrl_rst", CTRL_RESET, ctrl_q);
    cmp("out_en_rst", 8'h01, out_en);
    t_ignore();
    t_hold();
    t_now();
    t_delayed();
    t_sel();
    t_unlimited();
    print_verdict();
  end
endmodule
